/* File: logic/dfq_top.sv */
// dfq_top: dual synchronous queue with programmable threshold flags and APB slave
//
// How it works
// - side A has a 36-bit two-way data port
// - side A near-empty low when second queue low
// - side B near-empty low when first queue low
// - side A near-full low when first queue nearly full
// - side B near-full low when second queue nearly full
// - side A transfers taken on side A rising edge
// - default offsets 8/16/64 from flag select straps
// - flags assert exactly at threshold, deassert may lag
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dfq_top #(
   parameter int DEPTH = dfq_pkg::DEPTH_DEF
) (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   // side A pins
   input  wire logic                       sideAClock,
   input  wire logic                       sideAWriteEn,
   input  wire logic                       sideAReadEn,
   input  wire logic                       sideAOutputEn,
   input  wire logic [dfq_pkg::DATA_W-1:0] sideADataIn,
   output logic      [dfq_pkg::DATA_W-1:0] sideADataOut,
   output logic                            sideADataOe,
   output logic                            sideANearEmptyFlagN,
   output logic                            sideANearFullFlagN,
   // side B pins
   input  wire logic                       sideBClock,
   input  wire logic                       sideBWriteEn,
   input  wire logic                       sideBReadEn,
   input  wire logic [dfq_pkg::DATA_W-1:0] sideBDataIn,
   output logic      [dfq_pkg::DATA_W-1:0] sideBDataOut,
   output logic                            sideBNearEmptyFlagN,
   output logic                            sideBNearFullFlagN,
   // configuration straps
   input  wire logic                       busWidthSelect,
   input  wire logic                       flagSelectLow,
   input  wire logic                       flagSelectHigh,
   // apb slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [dfq_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   output logic                            irq
);
   localparam int CW    = $clog2(DEPTH) + 1;
   localparam int AW    = $clog2(DEPTH);
   localparam int DW    = dfq_pkg::DATA_W;
   localparam int PIN_W = 2 * DW + 10;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pinsRaw;
   logic [PIN_W-1:0] pinMeta_reg;
   logic [PIN_W-1:0] pinSync_reg;
   logic [1:0]       clkPrev_reg;
   logic             aClkSync;
   logic             bClkSync;
   logic             aWrSync;
   logic             aRdSync;
   logic             aOeSync;
   logic             bWrSync;
   logic             bRdSync;
   logic             bwSync;
   logic [1:0]       fsSync;
   logic [DW-1:0]    aDataSync;
   logic [DW-1:0]    bDataSync;
   logic             aEdge;
   logic             bEdge;

   assign pinsRaw = {sideAClock, sideBClock, sideAWriteEn, sideAReadEn, sideAOutputEn,
                     sideBWriteEn, sideBReadEn, busWidthSelect, flagSelectHigh,
                     flagSelectLow, sideADataIn, sideBDataIn};

   // two flops before any logic; data travels with its clock so they stay aligned
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pinMeta_reg <= '0;
         pinSync_reg <= '0;
      end else begin
         pinMeta_reg <= pinsRaw;
         pinSync_reg <= pinMeta_reg;
      end
   end

   assign {aClkSync, bClkSync, aWrSync, aRdSync, aOeSync, bWrSync, bRdSync, bwSync,
           fsSync, aDataSync, bDataSync} = pinSync_reg;

   // previous side clock levels for rising edge detection
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clkPrev_reg <= '0;
      end else begin
         clkPrev_reg <= {aClkSync, bClkSync};
      end
   end

   // side clocks may be unrelated or identical; each edge is found on its own
   assign aEdge = aClkSync & ~clkPrev_reg[1];
   assign bEdge = bClkSync & ~clkPrev_reg[0];

   // ----------------------------------------------------------------
   // queues: 0 is filled by side A, 1 is filled by side B
   // ----------------------------------------------------------------
   logic [1:0]    wrStb;
   logic [1:0]    rdStb;
   logic [1:0]    wrOk;
   logic [1:0]    rdOk;
   logic [DW-1:0] wrData [2];
   logic [DW-1:0] rdData [2];
   logic [CW-1:0] qCount [2];
   logic [CW-1:0] qNext [2];

   // side A words qualified on its rising edge only
   assign wrStb[0]  = aEdge & aWrSync;
   assign rdStb[1]  = aEdge & aRdSync;
   assign wrStb[1]  = bEdge & bWrSync;
   assign rdStb[0]  = bEdge & bRdSync;
   assign wrData[0] = aDataSync;
   assign wrData[1] = bDataSync;

   function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
      nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : nextPtr

   for (genvar q = 0; q < 2; q++) begin : gQueue
      logic [DW-1:0] mem [DEPTH];
      logic [AW-1:0] wrPtr_reg;
      logic [AW-1:0] rdPtr_reg;
      logic [CW-1:0] count_reg;
      logic [DW-1:0] rdData_reg;

      // a write to a full queue or a read of an empty one is dropped
      assign wrOk[q] = wrStb[q] & (count_reg != CW'(DEPTH));
      assign rdOk[q] = rdStb[q] & (count_reg != '0);

      // storage array, no reset needed
      always_ff @(posedge clk) begin
         if (wrOk[q]) begin
            mem[wrPtr_reg] <= wrData[q];
         end
      end

      // pointers and word count
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
         end else begin
            if (wrOk[q]) begin
               wrPtr_reg <= nextPtr(wrPtr_reg);
            end
            if (rdOk[q]) begin
               rdPtr_reg <= nextPtr(rdPtr_reg);
            end
            case ({wrOk[q], rdOk[q]})
               2'b10:   count_reg <= count_reg + 1'b1;
               2'b01:   count_reg <= count_reg - 1'b1;
               default: count_reg <= count_reg;
            endcase
         end
      end

      // read data register, holds last word read
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            rdData_reg <= '0;
         end else if (rdOk[q]) begin
            rdData_reg <= mem[rdPtr_reg];
         end
      end

      assign qCount[q] = count_reg;
      // count after this edge's transfer, so a flag asserts at the edge that reaches it
      assign qNext[q]  = count_reg + CW'(wrOk[q]) - CW'(rdOk[q]);
      assign rdData[q] = rdData_reg;
   end

   // side A drives its bus only when asked to
   assign sideADataOut = rdData[1];
   assign sideADataOe  = aOeSync;
   assign sideBDataOut = rdData[0];

   // ----------------------------------------------------------------
   // offsets and strap capture
   // ----------------------------------------------------------------
   logic [CW-1:0] q1NeOfs_reg;
   logic [CW-1:0] q2NeOfs_reg;
   logic [CW-1:0] q1NfOfs_reg;
   logic [CW-1:0] q2NfOfs_reg;
   logic [1:0]    strapCnt_reg;
   logic          strapLoad;
   logic          busWidth_reg;
   logic          apbAccess;
   logic          apbSetup;
   logic          apbWr;

   function automatic logic [CW-1:0] defaultOfs(input logic [1:0] fs);
      case (fs)
         dfq_pkg::FS_MID:   defaultOfs = CW'(dfq_pkg::DEF_OFS_MID);
         dfq_pkg::FS_LARGE: defaultOfs = CW'(dfq_pkg::DEF_OFS_LARGE);
         default:           defaultOfs = CW'(dfq_pkg::DEF_OFS_SMALL);
      endcase
   endfunction : defaultOfs

   // wait for the straps to pass the synchroniser before sampling them
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strapCnt_reg <= '0;
      end else if (strapCnt_reg != dfq_pkg::STRAP_WAIT) begin
         strapCnt_reg <= strapCnt_reg + 1'b1;
      end
   end

   assign strapLoad = (strapCnt_reg == dfq_pkg::STRAP_WAIT - 2'h1);
   assign apbSetup  = psel & ~penable;
   assign apbAccess = psel & penable;
   assign apbWr     = apbAccess & pwrite;

   // straps give defaults once; software may overwrite any offset later
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q1NeOfs_reg <= CW'(dfq_pkg::DEF_OFS_SMALL);
         q2NeOfs_reg <= CW'(dfq_pkg::DEF_OFS_SMALL);
         q1NfOfs_reg <= CW'(dfq_pkg::DEF_OFS_SMALL);
         q2NfOfs_reg <= CW'(dfq_pkg::DEF_OFS_SMALL);
      end else if (strapLoad) begin
         q1NeOfs_reg <= defaultOfs(fsSync);
         q2NeOfs_reg <= defaultOfs(fsSync);
         q1NfOfs_reg <= defaultOfs(fsSync);
         q2NfOfs_reg <= defaultOfs(fsSync);
      end else if (apbWr) begin
         case (paddr)
            dfq_pkg::OFS_Q1_NE: q1NeOfs_reg <= pwdata[CW-1:0];
            dfq_pkg::OFS_Q2_NE: q2NeOfs_reg <= pwdata[CW-1:0];
            dfq_pkg::OFS_Q1_NF: q1NfOfs_reg <= pwdata[CW-1:0];
            dfq_pkg::OFS_Q2_NF: q2NfOfs_reg <= pwdata[CW-1:0];
            default:            q1NeOfs_reg <= q1NeOfs_reg;
         endcase
      end
   end

   // bus width is taken once at the strap point; later changes are not expected
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busWidth_reg <= 1'b0;
      end else if (strapLoad) begin
         busWidth_reg <= bwSync;
      end
   end

   // ----------------------------------------------------------------
   // flag generator
   // ----------------------------------------------------------------
   dfq_flag_if #(.CW(CW)) flagBus ();

   assign flagBus.q1Count   = qNext[0];
   assign flagBus.q2Count   = qNext[1];
   assign flagBus.q1NeOfs   = q1NeOfs_reg;
   assign flagBus.q2NeOfs   = q2NeOfs_reg;
   assign flagBus.q1NfOfs   = q1NfOfs_reg;
   assign flagBus.q2NfOfs   = q2NfOfs_reg;
   assign flagBus.sideAEdge = aEdge;
   assign flagBus.sideBEdge = bEdge;

   dfq_flag_gen #(.DEPTH(DEPTH), .CW(CW)) uFlags (
      .clk  (clk),
      .rstn (rstn),
      .fif  (flagBus.gen)
   );

   assign sideANearEmptyFlagN = flagBus.flagsN[dfq_pkg::FLAG_A_NE];
   assign sideBNearEmptyFlagN = flagBus.flagsN[dfq_pkg::FLAG_B_NE];
   assign sideANearFullFlagN  = flagBus.flagsN[dfq_pkg::FLAG_A_NF];
   assign sideBNearFullFlagN  = flagBus.flagsN[dfq_pkg::FLAG_B_NF];

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   logic [dfq_pkg::NFLAGS-1:0] flagsPrev_reg;
   logic [dfq_pkg::NIRQ-1:0]   irqEvents;
   logic [dfq_pkg::NIRQ-1:0]   irqStat_reg;
   logic [dfq_pkg::NIRQ-1:0]   irqMask_reg;
   logic                       statRead;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flagsPrev_reg <= dfq_pkg::FLAGS_RST;
      end else begin
         flagsPrev_reg <= flagBus.flagsN;
      end
   end

   // events: a flag falling to asserted, or a word dropped at a full queue
   assign irqEvents = {wrStb & ~wrOk, flagsPrev_reg & ~flagBus.flagsN};
   assign statRead  = apbAccess & ~pwrite & (paddr == dfq_pkg::OFS_IRQ_STAT);

   // read clears, but a new event in the same cycle survives
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqStat_reg <= '0;
      end else begin
         irqStat_reg <= (statRead ? '0 : irqStat_reg) | irqEvents;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqMask_reg <= dfq_pkg::IRQ_MASK_RST;
      end else if (apbWr && paddr == dfq_pkg::OFS_IRQ_MASK) begin
         irqMask_reg <= pwdata[dfq_pkg::NIRQ-1:0];
      end
   end

   assign irq = |(irqStat_reg & irqMask_reg);

   // ----------------------------------------------------------------
   // apb slave: zero wait states, read data captured in the setup cycle
   // ----------------------------------------------------------------
   logic [31:0] prdata_reg;

   function automatic logic mapped(input logic [dfq_pkg::ADDR_W-1:0] a);
      case (a)
         dfq_pkg::OFS_Q1_NE, dfq_pkg::OFS_Q2_NE, dfq_pkg::OFS_Q1_NF, dfq_pkg::OFS_Q2_NF,
         dfq_pkg::OFS_COUNT, dfq_pkg::OFS_FLAGS, dfq_pkg::OFS_IRQ_STAT,
         dfq_pkg::OFS_IRQ_MASK: mapped = 1'b1;
         default:               mapped = 1'b0;
      endcase
   endfunction : mapped

   // status snapshot taken one cycle before the clearing edge; an event landing on the snapshot edge is cleared unread
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= '0;
      end else if (apbSetup && !pwrite) begin
         prdata_reg <= '0;
         case (paddr)
            dfq_pkg::OFS_Q1_NE:    prdata_reg[CW-1:0] <= q1NeOfs_reg;
            dfq_pkg::OFS_Q2_NE:    prdata_reg[CW-1:0] <= q2NeOfs_reg;
            dfq_pkg::OFS_Q1_NF:    prdata_reg[CW-1:0] <= q1NfOfs_reg;
            dfq_pkg::OFS_Q2_NF:    prdata_reg[CW-1:0] <= q2NfOfs_reg;
            dfq_pkg::OFS_COUNT: begin
               prdata_reg[CW-1:0] <= qCount[0];
               prdata_reg[dfq_pkg::CNT_Q2_LSB +: CW] <= qCount[1];
            end
            dfq_pkg::OFS_FLAGS: begin
               prdata_reg[dfq_pkg::NFLAGS-1:0] <= flagBus.flagsN;
               prdata_reg[dfq_pkg::FLAGS_BW]   <= busWidth_reg;
            end
            dfq_pkg::OFS_IRQ_STAT: prdata_reg[dfq_pkg::NIRQ-1:0] <= irqStat_reg;
            dfq_pkg::OFS_IRQ_MASK: prdata_reg[dfq_pkg::NIRQ-1:0] <= irqMask_reg;
            default:               prdata_reg <= '0;
         endcase
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = apbAccess & ~mapped(paddr);
endmodule : dfq_top
`default_nettype wire

/* File: pkg/dfq_pkg.sv */
// dfq_pkg: shared constants for the dual queue threshold flag block
package dfq_pkg;
   // ----------------------------------------------------------------
   // widths and sizes
   // ----------------------------------------------------------------
   localparam int DATA_W    = 36;
   localparam int DEPTH_DEF = 1024;
   localparam int ADDR_W    = 8;
   localparam int NFLAGS    = 4;
   localparam int NIRQ      = 6;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_Q1_NE    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_Q2_NE    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_Q1_NF    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_Q2_NF    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1C;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CNT_Q2_LSB  = 16;
   localparam int FLAGS_BW    = 4;
   localparam int FLAG_A_NE   = 0;
   localparam int FLAG_B_NE   = 1;
   localparam int FLAG_A_NF   = 2;
   localparam int FLAG_B_NF   = 3;
   localparam int IRQ_OVF_Q1  = 4;
   localparam int IRQ_OVF_Q2  = 5;

   // ----------------------------------------------------------------
   // reset values and default offsets
   // ----------------------------------------------------------------
   localparam logic [NFLAGS-1:0] FLAGS_RST    = 4'hC;
   localparam logic [NIRQ-1:0]   IRQ_MASK_RST = 6'h00;
   localparam int                DEF_OFS_SMALL = 8;
   localparam int                DEF_OFS_MID   = 16;
   localparam int                DEF_OFS_LARGE = 64;
   localparam logic [1:0]        FS_SMALL      = 2'h0;
   localparam logic [1:0]        FS_MID        = 2'h1;
   localparam logic [1:0]        FS_LARGE      = 2'h2;
   localparam logic [1:0]        STRAP_WAIT    = 2'h3;
endpackage : dfq_pkg

/* File: pkg/dfq_flag_if.sv */
// dfq_flag_if: counts, offsets and flags between queue core and flag generator
`timescale 1ns/1ps
`default_nettype none
interface dfq_flag_if #(parameter int CW = 11);
   logic [CW-1:0] q1Count;
   logic [CW-1:0] q2Count;
   logic [CW-1:0] q1NeOfs;
   logic [CW-1:0] q2NeOfs;
   logic [CW-1:0] q1NfOfs;
   logic [CW-1:0] q2NfOfs;
   logic          sideAEdge;
   logic          sideBEdge;
   logic [3:0]    flagsN;

   modport gen  (input q1Count, q2Count, q1NeOfs, q2NeOfs, q1NfOfs, q2NfOfs,
                 input sideAEdge, sideBEdge, output flagsN);
   modport user (output q1Count, q2Count, q1NeOfs, q2NeOfs, q1NfOfs, q2NfOfs,
                 output sideAEdge, sideBEdge, input flagsN);
endinterface : dfq_flag_if
`default_nettype wire

/* File: logic/dfq_flag_gen.sv */
// dfq_flag_gen: active-low near-empty and near-full flag generation
`timescale 1ns/1ps
`default_nettype none
module dfq_flag_gen #(
   parameter int DEPTH = dfq_pkg::DEPTH_DEF,
   parameter int CW    = $clog2(DEPTH) + 1
) (
   input  wire logic  clk,
   input  wire logic  rstn,
   dfq_flag_if.gen    fif
);
   // ----------------------------------------------------------------
   // threshold compare
   // ----------------------------------------------------------------
   function automatic logic atOrBelow(input logic [CW-1:0] val, input logic [CW-1:0] lim);
      atOrBelow = (val <= lim);
   endfunction : atOrBelow

   logic [CW-1:0]     q1Free;
   logic [CW-1:0]     q2Free;
   logic [3:0]        flagsN_reg;

   // free locations derived from word count
   assign q1Free = CW'(DEPTH) - fif.q1Count;
   assign q2Free = CW'(DEPTH) - fif.q2Count;

   // each flag only moves on its own side's clock edge; low means asserted
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flagsN_reg <= dfq_pkg::FLAGS_RST;
      end else begin
         if (fif.sideAEdge) begin
            flagsN_reg[dfq_pkg::FLAG_A_NE] <= !atOrBelow(fif.q2Count, fif.q2NeOfs);
            flagsN_reg[dfq_pkg::FLAG_A_NF] <= !atOrBelow(q1Free, fif.q1NfOfs);
         end
         if (fif.sideBEdge) begin
            flagsN_reg[dfq_pkg::FLAG_B_NE] <= !atOrBelow(fif.q1Count, fif.q1NeOfs);
            flagsN_reg[dfq_pkg::FLAG_B_NF] <= !atOrBelow(q2Free, fif.q2NfOfs);
         end
      end
   end

   // counts include this edge's transfer, so assertion is exact
   assign fif.flagsN = flagsN_reg;
endmodule : dfq_flag_gen
`default_nettype wire

/* File: sim/dfq_side_model.sv */
// dfq_side_model: processor-like party on one side port of the queue block
`timescale 1ns/1ps
`default_nettype none
module dfq_side_model (
   input  wire logic                  clk,
   output logic                       sideClock,
   output logic                       writeEn,
   output logic                       readEn,
   output logic                       drive,
   output logic [dfq_pkg::DATA_W-1:0] data
);
   // side clock low between transfers; a released bus shows the inverse
   initial begin
      {sideClock, writeEn, readEn, drive} = 4'h0;
      data = '0;
   end
   // enables lead and trail the rise, as they share the clock's two-flop path
   task automatic xfer(input logic wr, input logic rd, input logic [dfq_pkg::DATA_W-1:0] d);
      @(posedge clk);
      {writeEn, readEn, drive} <= {wr, rd, wr};
      data <= wr ? d : ~data;
      repeat (3) @(posedge clk);
      sideClock <= 1'h1;
      repeat (3) @(posedge clk);
      sideClock <= 1'h0;
      repeat (2) @(posedge clk);
      {writeEn, readEn, drive} <= 3'h0;
      data <= ~data;
      repeat (2) @(posedge clk);
   endtask : xfer
endmodule : dfq_side_model
`default_nettype wire

/* File: sim/dfq_top_asserts.sv */
// dfq_top_asserts: port-level checker for the queue flag block
`timescale 1ns/1ps
`default_nettype none
module dfq_top_asserts (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        sideAClock,
   input wire logic        sideBClock,
   input wire logic        sideAOutputEn,
   input wire logic [35:0] sideADataOut,
   input wire logic [35:0] sideBDataOut,
   input wire logic        sideADataOe,
   input wire logic        sideANearEmptyFlagN,
   input wire logic        sideANearFullFlagN,
   input wire logic        sideBNearEmptyFlagN,
   input wire logic        sideBNearFullFlagN,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [5:0] aHist_reg;
   logic [5:0] bHist_reg;
   // recent side clock samples; six deep covers the sync path plus data latency
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {aHist_reg, bHist_reg} <= '0;
      end else begin
         {aHist_reg, bHist_reg} <= {aHist_reg[4:0], sideAClock, bHist_reg[4:0], sideBClock};
      end
   end
   a_flag_sync_a: assert property ($changed({sideANearEmptyFlagN, sideANearFullFlagN})
      |-> |aHist_reg) else $error("A flag moved off A clock");
   a_flag_sync_b: assert property ($changed({sideBNearEmptyFlagN, sideBNearFullFlagN})
      |-> |bHist_reg) else $error("B flag moved off B clock");
   a_word_sync_a: assert property ($changed(sideADataOut) |-> |aHist_reg)
      else $error("A word moved off A clock");
   a_word_sync_b: assert property ($changed(sideBDataOut) |-> |bHist_reg)
      else $error("B word moved off B clock");
   a_oe_follows: assert property ($past(rstn, 1) && $past(rstn, 2)
      |-> sideADataOe == $past(sideAOutputEn, 2)) else $error("A enable delay wrong");
   a_err_unmapped: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
      else $error("unmapped no error");
   a_err_mapped: assert property (psel && penable && paddr <= 8'h1C && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("mapped error");
   a_zero_unmapped: assert property (psel && penable && !pwrite && paddr > 8'h1C
      |-> prdata == 32'h0000_0000) else $error("unmapped read nonzero");
   a_ready_next: assert property (psel && !penable |=> pready) else $error("not ready");
   a_mask_off: assert property (psel && penable && pwrite && paddr == dfq_pkg::OFS_IRQ_MASK
      && pwdata[5:0] == 6'h00 |=> !irq) else $error("irq while masked");
   c_irq: cover property (irq);
   c_ne_fall: cover property ($fell(sideBNearEmptyFlagN));
   c_slverr: cover property (pslverr);
endmodule : dfq_top_asserts
bind dfq_top dfq_top_asserts u_asserts (.*);
`default_nettype wire

/* File: sim/tb.sv */
// tb: self-checking bench for the dual queue threshold flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr, irq, e, bws, fsl, fsh;
   logic        aOe, aDataOe, aNe, aNf, bNe, bNf, aClk, aWr, aRd, aDrv, bClk, bWr, bRd;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [35:0] aData, aBus, aOut, bData, bOut;
   int          n_errors, n_compared;
   int          defOfs[4] = '{8, 16, 64, 8};
   // side A bus: design drives it when enabled and the model is quiet
   assign aBus = (aDataOe && !aDrv) ? aOut : aData;
   dfq_side_model pa (.clk(clk), .sideClock(aClk), .writeEn(aWr), .readEn(aRd),
      .drive(aDrv), .data(aData));
   dfq_side_model pb (.clk(clk), .sideClock(bClk), .writeEn(bWr), .readEn(bRd),
      .drive(), .data(bData));
   dfq_top uut (.clk(clk), .rstn(rstn), .sideAClock(aClk), .sideAWriteEn(aWr),
      .sideAReadEn(aRd), .sideAOutputEn(aOe), .sideADataIn(aBus), .sideADataOut(aOut),
      .sideADataOe(aDataOe), .sideANearEmptyFlagN(aNe), .sideANearFullFlagN(aNf),
      .sideBClock(bClk), .sideBWriteEn(bWr), .sideBReadEn(bRd), .sideBDataIn(bData),
      .sideBDataOut(bOut), .sideBNearEmptyFlagN(bNe), .sideBNearFullFlagN(bNf),
      .busWidthSelect(bws), .flagSelectLow(fsl), .flagSelectHigh(fsh), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq));
   // 50 ns period
   always #25 clk = ~clk;
   // ----------------------------------------------------------------
   // compare, bus and run control tasks
   // ----------------------------------------------------------------
   task automatic chkw(input logic [35:0] got, input logic [35:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask : chkw
   task automatic chkb(input logic got, input logic exp, input string m);
      chkw({35'h0, got}, {35'h0, exp}, m);
   endtask : chkb
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   // setup, then access held until pready; bounded wait
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge clk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'h1 && k < 20);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
      if (k >= 20) begin
         n_errors++;
         $display("unexpected at %0t: no bus answer", $time);
         results();
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string m);
      apb(1'h0, a, 32'h0000_0000);
      chkw({4'h0, r}, {4'h0, x}, m);
   endtask : rdc
   // straps settle while reset is low
   task automatic do_reset(input logic [1:0] code);
      {fsh, fsl} <= code;
      rstn <= 1'h0;
      repeat (12) @(posedge clk);
      rstn <= 1'h1;
      repeat (5) @(posedge clk);
   endtask : do_reset
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'h0;
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      {bws, fsl, fsh, aOe} = 4'h8; // width strap held for the whole run
      n_errors = 0;
      n_compared = 0;
      for (int i = 0; i < 4; i++) begin
         do_reset(i[1:0]);
         rdc(dfq_pkg::OFS_Q1_NE, defOfs[i], "default ofs");
      end
      rdc(dfq_pkg::OFS_FLAGS, 32'h0000_001C, "reset flags");
      chkb(aNf, 1'h1, "reset a nf");
      rdc(8'h40, 32'h0000_0000, "unmapped");
      chkb(e, 1'h1, "unmapped err");
      $display("test straps done");
      wr(dfq_pkg::OFS_Q1_NE, 32'h0000_0002);
      wr(dfq_pkg::OFS_Q2_NE, 32'h0000_0001);
      wr(dfq_pkg::OFS_Q1_NF, 32'h0000_03FD);
      wr(dfq_pkg::OFS_Q2_NF, 32'h0000_03FE);
      wr(dfq_pkg::OFS_IRQ_MASK, 32'h0000_0002);
      rdc(dfq_pkg::OFS_Q2_NF, 32'h0000_03FE, "ofs readback");
      // first queue: a flag asserts at the own-side edge whose transfer reaches it
      pa.xfer(1'h1, 1'h0, 36'h9_A5C3_0F17);
      pa.xfer(1'h1, 1'h0, 36'h2_5A3C_F0E1);
      pb.xfer(1'h0, 1'h0, '0);
      chkb(bNe, 1'h0, "b ne at ofs");
      pa.xfer(1'h0, 1'h0, '0);
      chkb(aNf, 1'h1, "a nf above");
      pa.xfer(1'h1, 1'h0, 36'h7_1234_5678);
      chkb(aNf, 1'h0, "a nf at ofs");
      pb.xfer(1'h0, 1'h0, '0);
      chkb(bNe, 1'h1, "b ne above");
      chkb(irq, 1'h0, "masked event");
      rdc(dfq_pkg::OFS_COUNT, 32'h0000_0003, "count");
      pb.xfer(1'h0, 1'h1, '0);
      chkw(bOut, 36'h9_A5C3_0F17, "b word");
      chkb(bNe, 1'h0, "b ne back");
      chkb(irq, 1'h1, "unmasked event");
      rdc(dfq_pkg::OFS_IRQ_STAT, 32'h0000_0006, "status");
      @(posedge clk);
      chkb(irq, 1'h0, "irq cleared");
      $display("test first queue done");
      // second queue, read back through side A with the bus turned around
      aOe <= 1'h1;
      pb.xfer(1'h1, 1'h0, 36'h3_0F0F_C3C3);
      pb.xfer(1'h0, 1'h0, '0);
      chkb(bNf, 1'h1, "b nf above");
      pb.xfer(1'h1, 1'h0, 36'h4_8421_1248);
      chkb(bNf, 1'h0, "b nf at ofs");
      pa.xfer(1'h0, 1'h0, '0);
      chkb(aNe, 1'h1, "a ne above");
      pa.xfer(1'h0, 1'h1, '0);
      chkw(aOut, 36'h3_0F0F_C3C3, "a word");
      chkb(aDataOe, 1'h1, "a driven");
      chkb(aNe, 1'h0, "a ne at ofs");
      wr(dfq_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      rdc(dfq_pkg::OFS_IRQ_STAT, 32'h0000_0009, "second events");
      $display("test second queue done");
      results();
   end
endmodule : tb
`default_nettype wire
